/* File: hdl/smt_pkg.sv */
// Shared constants, register map and carrier types for the core block.
package smt_pkg;

   // Thread and data geometry.
   localparam int NUM_THR = 2;
   localparam int TID_W   = 1;
   localparam int ADDR_W  = 32;
   localparam int DATA_W  = 64;

   // Register addresses.
   localparam logic [ADDR_W-1:0] ADDR_SIG    = 32'h0000_008b;
   localparam logic [ADDR_W-1:0] ADDR_MISC   = 32'h0000_01a0;
   localparam logic [ADDR_W-1:0] ADDR_ALLOC  = 32'h0000_0300;
   localparam logic [ADDR_W-1:0] ADDR_CTR0   = 32'h0000_0310;
   localparam logic [ADDR_W-1:0] ADDR_CTR1   = 32'h0000_0311;
   localparam logic [ADDR_W-1:0] ADDR_EVSEL0 = 32'h0000_0320;
   localparam logic [ADDR_W-1:0] ADDR_EVSEL1 = 32'h0000_0321;
   localparam logic [ADDR_W-1:0] ADDR_UPD    = 32'h0000_0330;
   localparam logic [ADDR_W-1:0] ADDR_STAT   = 32'h0000_0331;
   localparam logic [ADDR_W-1:0] ADDR_IDENT  = 32'h0000_0340;

   // Reset values.
   localparam logic [DATA_W-1:0] MISC_RST = 64'h0000_0000_0000_0000;
   localparam logic [DATA_W-1:0] SIG_RST  = 64'h0000_0000_0000_0000;

   // Performance counters and per-thread event selection fields.
   localparam int NUM_CTR       = 2;
   localparam int CTR_W         = 48;
   localparam int EVT_W         = 8;
   localparam int EVSEL_W       = 6;
   localparam int EVSEL_EVT_LSB = 0;
   localparam int EVSEL_EVT_W   = 3;
   localparam int EVSEL_EN_BIT  = 3;
   localparam int EVSEL_INT_BIT = 4;
   localparam int EVSEL_PEB_BIT = 5;

   // Status word fields.
   localparam int STAT_OVF_LSB  = 0;
   localparam int STAT_BUSY_BIT = 8;
   localparam int STAT_PEND_BIT = 9;

   // Update signature field and update timing.
   localparam int SIG_LSB        = 32;
   localparam int SIG_W          = 32;
   localparam int CLK_PERIOD_NS  = 8;
   localparam int UPD_TIME_NS    = 1000;
   localparam int UPD_CYCLES     =
      (UPD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UPD_CNT_W      = 8;

   // Identifier geometry.
   localparam int ID_W       = 8;
   localparam int PKG_W      = 4;
   localparam int CLU_W      = 2;
   localparam int CORE_W_MAX = 2;
   localparam int CWID_W     = 2;

   // Register selector produced by the address decoder.
   typedef enum logic [3:0] {
      REG_SIG, REG_MISC, REG_ALLOC, REG_CTR0, REG_CTR1,
      REG_EVSEL0, REG_EVSEL1, REG_UPD, REG_STAT, REG_IDENT, REG_NONE
   } smt_reg_t;

   // One model-specific register access from a thread.
   typedef struct packed {
      logic              vld;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } smt_req_t;

   // Answer to one access.
   typedef struct packed {
      logic              ack;
      logic              err;
      logic [DATA_W-1:0] rdata;
   } smt_rsp_t;

endpackage : smt_pkg

/* File: hdl/smt_pmu_ctr.sv */
// Shared performance counter bank of one core.
`timescale 1ns/100ps
module smt_pmu_ctr (
   input  wire logic                                         clk,
   input  wire logic                                         sys_rst,
   input  wire logic [smt_pkg::NUM_CTR-1:0]                  inc,
   input  wire logic [smt_pkg::NUM_CTR-1:0]                  wr,
   input  wire logic [smt_pkg::NUM_CTR-1:0][smt_pkg::CTR_W-1:0] wdata,
   output logic      [smt_pkg::NUM_CTR-1:0][smt_pkg::CTR_W-1:0] ctr_q,
   output logic      [smt_pkg::NUM_CTR-1:0]                  ovf
);

   // One storage copy per counter; a write beats a count in the same cycle.
   always_ff @(posedge clk) begin
      for (int i = 0; i < smt_pkg::NUM_CTR; i++) begin
         if (sys_rst) begin
            ctr_q[i] <= '0;
            ovf[i]   <= 1'b0;
         end else begin
            ovf[i] <= inc[i] && !wr[i] && (&ctr_q[i]);
            if (wr[i]) begin
               ctr_q[i] <= wdata[i];
            end else if (inc[i]) begin
               ctr_q[i] <= ctr_q[i] + smt_pkg::CTR_W'(1);
            end
         end
      end
   end

endmodule : smt_pmu_ctr

/* File: hdl/smt_upd_arb.sv */
// Serialiser for update requests from the two threads of a core.
`timescale 1ns/100ps
module smt_upd_arb (
   input  wire logic                                          clk,
   input  wire logic                                          sys_rst,
   input  wire logic [smt_pkg::NUM_THR-1:0]                   req,
   input  wire logic [smt_pkg::NUM_THR-1:0][smt_pkg::SIG_W-1:0] req_sig,
   output logic      [smt_pkg::NUM_THR-1:0]                   pend_q,
   output logic                                               busy,
   output logic                                               done_q,
   output logic      [smt_pkg::SIG_W-1:0]                     sig_q
);

   typedef enum logic {ARB_IDLE, ARB_RUN} smt_arb_st_t;

   smt_arb_st_t                                     st_q;
   logic [smt_pkg::NUM_THR-1:0][smt_pkg::SIG_W-1:0] data_q;
   logic [smt_pkg::NUM_THR-1:0]                     grant;
   logic                                            last_q;
   logic [smt_pkg::UPD_CNT_W-1:0]                   cnt_q;

   // Grant one pending request at a time, alternating when both wait.
   always_comb begin
      grant = '0;
      if (st_q == ARB_IDLE) begin
         if (pend_q[0] && (!pend_q[1] || last_q)) begin
            grant[0] = 1'b1;
         end else if (pend_q[1]) begin
            grant[1] = 1'b1;
         end
      end
   end

   assign busy = (st_q == ARB_RUN);

   // Pending flags; a new request wins over its own grant.
   always_ff @(posedge clk) begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         if (sys_rst) begin
            pend_q[t] <= 1'b0;
            data_q[t] <= '0;
         end else begin
            if (req[t]) begin
               pend_q[t] <= 1'b1;
               data_q[t] <= req_sig[t];
            end else if (grant[t]) begin
               pend_q[t] <= 1'b0;
            end
         end
      end
   end

   // Update sequencer: runs one update for the whole core.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q   <= ARB_IDLE;
         cnt_q  <= '0;
         last_q <= 1'b0;
         done_q <= 1'b0;
         sig_q  <= '0;
      end else begin
         done_q <= 1'b0;
         case (st_q)
            ARB_IDLE: begin
               if (|grant) begin
                  st_q   <= ARB_RUN;
                  last_q <= grant[1];
                  sig_q  <= grant[1] ? data_q[1] : data_q[0];
                  cnt_q  <= smt_pkg::UPD_CNT_W'(smt_pkg::UPD_CYCLES - 1);
               end
            end
            ARB_RUN: begin
               if (cnt_q == '0) begin
                  st_q   <= ARB_IDLE;
                  done_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - smt_pkg::UPD_CNT_W'(1);
               end
            end
            default: begin
               st_q <= ARB_IDLE;
            end
         endcase
      end
   end

endmodule : smt_upd_arb

/* File: hdl/smt_core.sv */
// Shared and per-thread resources of one two-thread core.
`timescale 1ns/100ps
module smt_core (
   input  wire logic                                          clk,
   input  wire logic                                          sys_rst,
   input  wire smt_pkg::smt_req_t [smt_pkg::NUM_THR-1:0]      req,
   output smt_pkg::smt_rsp_t      [smt_pkg::NUM_THR-1:0]      rsp,
   input  wire logic [smt_pkg::NUM_THR-1:0][smt_pkg::EVT_W-1:0] events,
   input  wire logic [smt_pkg::CLU_W-1:0]                     cluster_index,
   input  wire logic [smt_pkg::PKG_W-1:0]                     socket_index,
   input  wire logic [smt_pkg::CORE_W_MAX-1:0]                processor_core_index,
   input  wire logic [smt_pkg::CWID_W-1:0]                    core_field_width,
   output logic      [smt_pkg::DATA_W-1:0]                    misc_feature_enable,
   output logic [smt_pkg::NUM_THR-1:0][smt_pkg::ID_W-1:0]
                     initial_interrupt_controller_identifier,
   output logic      [smt_pkg::NUM_THR-1:0]                   primary_thread,
   output logic      [smt_pkg::NUM_THR-1:0]                   ctr_irq,
   output logic      [smt_pkg::NUM_THR-1:0]                   precise_hit,
   output logic                                               upd_busy
);

   // Address decoder shared by both thread ports.
   function automatic smt_pkg::smt_reg_t dec_addr(
      input logic [smt_pkg::ADDR_W-1:0] a
   );
      smt_pkg::smt_reg_t r;
      r = smt_pkg::REG_NONE;
      case (a)
         smt_pkg::ADDR_SIG:    r = smt_pkg::REG_SIG;
         smt_pkg::ADDR_MISC:   r = smt_pkg::REG_MISC;
         smt_pkg::ADDR_ALLOC:  r = smt_pkg::REG_ALLOC;
         smt_pkg::ADDR_CTR0:   r = smt_pkg::REG_CTR0;
         smt_pkg::ADDR_CTR1:   r = smt_pkg::REG_CTR1;
         smt_pkg::ADDR_EVSEL0: r = smt_pkg::REG_EVSEL0;
         smt_pkg::ADDR_EVSEL1: r = smt_pkg::REG_EVSEL1;
         smt_pkg::ADDR_UPD:    r = smt_pkg::REG_UPD;
         smt_pkg::ADDR_STAT:   r = smt_pkg::REG_STAT;
         smt_pkg::ADDR_IDENT:  r = smt_pkg::REG_IDENT;
         default:              r = smt_pkg::REG_NONE;
      endcase
      return r;
   endfunction : dec_addr

   // Builds the identifier of one thread from the captured topology.
   function automatic logic [smt_pkg::ID_W-1:0] compose_id(
      input logic [smt_pkg::CLU_W-1:0]      clu,
      input logic [smt_pkg::PKG_W-1:0]      pkg,
      input logic [smt_pkg::CORE_W_MAX-1:0] core,
      input logic [smt_pkg::CWID_W-1:0]     cw_in,
      input logic [smt_pkg::TID_W-1:0]      thr
   );
      logic [15:0]                  acc;
      logic [smt_pkg::CORE_W_MAX-1:0] core_m;
      int                           cw;
      acc = '0;
      core_m = '0;
      cw = int'(cw_in);
      if (cw > smt_pkg::CORE_W_MAX) begin
         cw = smt_pkg::CORE_W_MAX;
      end
      // A zero width leaves no core bits at all.
      core_m = core & ~({smt_pkg::CORE_W_MAX{1'b1}} << cw);
      acc = 16'(thr);
      acc = acc | (16'(core_m) << smt_pkg::TID_W);
      acc = acc | (16'(pkg) << (smt_pkg::TID_W + cw));
      acc = acc | (16'(clu) << (smt_pkg::TID_W + cw + smt_pkg::PKG_W));
      return acc[smt_pkg::ID_W-1:0];
   endfunction : compose_id

   smt_pkg::smt_reg_t [smt_pkg::NUM_THR-1:0]             reg_sel;
   logic [smt_pkg::NUM_THR-1:0]                          wr_any;
   logic [smt_pkg::NUM_THR-1:0]                          wr_misc;
   logic [smt_pkg::NUM_THR-1:0]                          wr_alloc;
   logic [smt_pkg::NUM_THR-1:0]                          wr_upd;
   logic [smt_pkg::NUM_THR-1:0]                          wr_stat;
   logic [smt_pkg::NUM_THR-1:0]                          wr_sig;
   logic [smt_pkg::NUM_THR-1:0][smt_pkg::NUM_CTR-1:0]    wr_ctr;
   logic [smt_pkg::NUM_THR-1:0][smt_pkg::NUM_CTR-1:0]    wr_evsel;
   logic [smt_pkg::NUM_THR-1:0][smt_pkg::DATA_W-1:0]     rd_val;
   logic [smt_pkg::NUM_THR-1:0][smt_pkg::DATA_W-1:0]     stat_w;
   logic [smt_pkg::NUM_THR-1:0]                          rd_err;
   logic [smt_pkg::DATA_W-1:0]                           misc_q;
   logic [smt_pkg::NUM_CTR-1:0]                          alloc_q;
   logic [smt_pkg::NUM_THR-1:0][smt_pkg::NUM_CTR-1:0][smt_pkg::EVSEL_W-1:0]
                                                         evsel_q;
   logic [smt_pkg::NUM_THR-1:0][smt_pkg::NUM_CTR-1:0]    ovf_q;
   logic [smt_pkg::NUM_THR-1:0]                          precise_q;
   logic [smt_pkg::NUM_THR-1:0][smt_pkg::DATA_W-1:0]     sig_q;
   logic [smt_pkg::NUM_THR-1:0][smt_pkg::ID_W-1:0]       ident_q;
   smt_pkg::smt_rsp_t [smt_pkg::NUM_THR-1:0]             rsp_q;
   logic [smt_pkg::NUM_CTR-1:0]                          ctr_inc;
   logic [smt_pkg::NUM_CTR-1:0]                          ctr_wr;
   logic [smt_pkg::NUM_CTR-1:0][smt_pkg::CTR_W-1:0]      ctr_wdata;
   logic [smt_pkg::NUM_CTR-1:0][smt_pkg::CTR_W-1:0]      ctr_val;
   logic [smt_pkg::NUM_CTR-1:0]                          ctr_ovf;
   logic [smt_pkg::NUM_THR-1:0]                          upd_req;
   logic [smt_pkg::NUM_THR-1:0][smt_pkg::SIG_W-1:0]      upd_req_sig;
   logic [smt_pkg::NUM_THR-1:0]                          upd_pend;
   logic                                                 upd_done;
   logic [smt_pkg::SIG_W-1:0]                            upd_sig;

   // Decode each thread's access into per-register write strobes.
   always_comb begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         reg_sel[t]  = dec_addr(req[t].addr);
         wr_any[t]   = req[t].vld && req[t].wr;
         wr_misc[t]  = wr_any[t] && (reg_sel[t] == smt_pkg::REG_MISC);
         wr_alloc[t] = wr_any[t] && (reg_sel[t] == smt_pkg::REG_ALLOC);
         wr_upd[t]   = wr_any[t] && (reg_sel[t] == smt_pkg::REG_UPD);
         wr_stat[t]  = wr_any[t] && (reg_sel[t] == smt_pkg::REG_STAT);
         wr_sig[t]   = wr_any[t] && (reg_sel[t] == smt_pkg::REG_SIG);
         wr_ctr[t][0]   = wr_any[t] && (reg_sel[t] == smt_pkg::REG_CTR0);
         wr_ctr[t][1]   = wr_any[t] && (reg_sel[t] == smt_pkg::REG_CTR1);
         wr_evsel[t][0] = wr_any[t] && (reg_sel[t] == smt_pkg::REG_EVSEL0);
         wr_evsel[t][1] = wr_any[t] && (reg_sel[t] == smt_pkg::REG_EVSEL1);
      end
   end

   // Status word seen by each thread: its overflows and update progress.
   always_comb begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         stat_w[t] = '0;
         stat_w[t][smt_pkg::STAT_OVF_LSB +: smt_pkg::NUM_CTR] = ovf_q[t];
         stat_w[t][smt_pkg::STAT_BUSY_BIT] = upd_busy;
         stat_w[t][smt_pkg::STAT_PEND_BIT] = upd_pend[t];
      end
   end

   // Read multiplexer; shared storage is the same for both threads.
   always_comb begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         rd_val[t] = '0;
         rd_err[t] = 1'b0;
         case (reg_sel[t])
            smt_pkg::REG_SIG:    rd_val[t] = sig_q[t];
            smt_pkg::REG_MISC:   rd_val[t] = misc_q;
            smt_pkg::REG_ALLOC:  rd_val[t] = smt_pkg::DATA_W'(alloc_q);
            smt_pkg::REG_CTR0:   rd_val[t] = smt_pkg::DATA_W'(ctr_val[0]);
            smt_pkg::REG_CTR1:   rd_val[t] = smt_pkg::DATA_W'(ctr_val[1]);
            smt_pkg::REG_EVSEL0: rd_val[t] = smt_pkg::DATA_W'(evsel_q[t][0]);
            smt_pkg::REG_EVSEL1: rd_val[t] = smt_pkg::DATA_W'(evsel_q[t][1]);
            smt_pkg::REG_UPD:    rd_val[t] = '0;
            smt_pkg::REG_STAT:   rd_val[t] = stat_w[t];
            smt_pkg::REG_IDENT:  rd_val[t] = smt_pkg::DATA_W'(ident_q[t]);
            default:             rd_err[t] = 1'b1;
         endcase
      end
   end

   // Answers: one cycle after each access, reads carry data, misses flag.
   always_ff @(posedge clk) begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         if (sys_rst) begin
            rsp_q[t] <= '0;
         end else begin
            rsp_q[t].ack   <= req[t].vld;
            rsp_q[t].err   <= req[t].vld && rd_err[t];
            rsp_q[t].rdata <= (req[t].vld && !req[t].wr) ? rd_val[t] : '0;
         end
      end
   end

   assign rsp = rsp_q;

   // Single feature-enable copy; thread 0 wins a same-cycle write clash.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         misc_q <= smt_pkg::MISC_RST;
      end else if (wr_misc[0]) begin
         misc_q <= req[0].wdata;
      end else if (wr_misc[1]) begin
         misc_q <= req[1].wdata;
      end
   end

   // Both threads see the very same enable bits.
   assign misc_feature_enable = misc_q;

   // Counter allocation: bit i names the thread that owns counter i.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alloc_q <= '0;
      end else if (wr_alloc[0]) begin
         alloc_q <= req[0].wdata[smt_pkg::NUM_CTR-1:0];
      end else if (wr_alloc[1]) begin
         alloc_q <= req[1].wdata[smt_pkg::NUM_CTR-1:0];
      end
   end

   // Per-thread event selection for every counter.
   always_ff @(posedge clk) begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         for (int i = 0; i < smt_pkg::NUM_CTR; i++) begin
            if (sys_rst) begin
               evsel_q[t][i] <= '0;
            end else if (wr_evsel[t][i]) begin
               evsel_q[t][i] <= req[t].wdata[smt_pkg::EVSEL_W-1:0];
            end
         end
      end
   end

   // Counting follows the owner's selection; thread 0 wins a same-cycle counter write clash.
   always_comb begin
      for (int i = 0; i < smt_pkg::NUM_CTR; i++) begin
         ctr_inc[i] = evsel_q[alloc_q[i]][i][smt_pkg::EVSEL_EN_BIT] &&
                      events[alloc_q[i]][evsel_q[alloc_q[i]][i]
                         [smt_pkg::EVSEL_EVT_LSB +: smt_pkg::EVSEL_EVT_W]];
         ctr_wr[i]    = wr_ctr[0][i] || wr_ctr[1][i];
         ctr_wdata[i] = wr_ctr[0][i] ? req[0].wdata[smt_pkg::CTR_W-1:0]
                                     : req[1].wdata[smt_pkg::CTR_W-1:0];
      end
   end

   // Shared counter bank of this core.
   smt_pmu_ctr u_pmu (
      .clk     (clk),
      .sys_rst (sys_rst),
      .inc     (ctr_inc),
      .wr      (ctr_wr),
      .wdata   (ctr_wdata),
      .ctr_q   (ctr_val),
      .ovf     (ctr_ovf)
   );

   // Overflow flags go to the owning thread; a new overflow beats a clear.
   always_ff @(posedge clk) begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         for (int i = 0; i < smt_pkg::NUM_CTR; i++) begin
            if (sys_rst) begin
               ovf_q[t][i] <= 1'b0;
            end else if (ctr_ovf[i] &&
                         (alloc_q[i] == smt_pkg::TID_W'(t)) &&
                         evsel_q[t][i][smt_pkg::EVSEL_INT_BIT]) begin
               ovf_q[t][i] <= 1'b1;
            end else if (wr_stat[t] &&
                         req[t].wdata[smt_pkg::STAT_OVF_LSB + i]) begin
               ovf_q[t][i] <= 1'b0;
            end
         end
      end
   end

   // Precise-monitoring hit pulses, again only to the owning thread.
   always_ff @(posedge clk) begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         if (sys_rst) begin
            precise_q[t] <= 1'b0;
         end else begin
            precise_q[t] <= 1'b0;
            for (int i = 0; i < smt_pkg::NUM_CTR; i++) begin
               if (ctr_ovf[i] && (alloc_q[i] == smt_pkg::TID_W'(t)) &&
                   evsel_q[t][i][smt_pkg::EVSEL_PEB_BIT]) begin
                  precise_q[t] <= 1'b1;
               end
            end
         end
      end
   end

   // Interrupt level per thread follows its own sticky flags.
   always_comb begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         ctr_irq[t] = |ovf_q[t];
      end
   end

   assign precise_hit = precise_q;

   // Either thread may start an update; the serialiser takes it from here.
   always_comb begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         upd_req[t]     = wr_upd[t];
         upd_req_sig[t] = req[t].wdata[smt_pkg::SIG_W-1:0];
      end
   end

   // One update engine per core, never two updates at once.
   smt_upd_arb u_upd (
      .clk     (clk),
      .sys_rst (sys_rst),
      .req     (upd_req),
      .req_sig (upd_req_sig),
      .pend_q  (upd_pend),
      .busy    (upd_busy),
      .done_q  (upd_done),
      .sig_q   (upd_sig)
   );

   // Signature per thread; a finished update overrides a software write.
   always_ff @(posedge clk) begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         if (sys_rst) begin
            sig_q[t] <= smt_pkg::SIG_RST;
         end else if (upd_done) begin
            sig_q[t] <= smt_pkg::DATA_W'(upd_sig) << smt_pkg::SIG_LSB;
         end else if (wr_sig[t]) begin
            sig_q[t] <= req[t].wdata;
         end
      end
   end

   // Identifiers are taken from the topology inputs while reset is held.
   always_ff @(posedge clk) begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         if (sys_rst) begin
            ident_q[t] <= compose_id(cluster_index, socket_index,
                                     processor_core_index, core_field_width,
                                     smt_pkg::TID_W'(t));
         end
      end
   end

   assign initial_interrupt_controller_identifier = ident_q;

   // Thread 0 is the primary logical processor of the core.
   always_comb begin
      for (int t = 0; t < smt_pkg::NUM_THR; t++) begin
         primary_thread[t] = (ident_q[t][smt_pkg::TID_W-1:0] == '0);
      end
   end

endmodule : smt_core

/* File: tb/smt_core_checker.sv */
// Port-level checks for the core block.
`timescale 1ns/100ps
module smt_core_checker (
   input wire logic                                    clk,
   input wire logic                                    sys_rst,
   input wire smt_pkg::smt_req_t [smt_pkg::NUM_THR-1:0] req,
   input wire smt_pkg::smt_rsp_t [smt_pkg::NUM_THR-1:0] rsp,
   input wire logic [1:0][7:0]          initial_interrupt_controller_identifier,
   input wire logic [1:0]                              primary_thread,
   input wire logic                                    upd_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Short alias for the identifier pair.
   wire logic [1:0][7:0] id = initial_interrupt_controller_identifier;
   sequence s_trig;
      req[0].vld && req[0].wr && req[0].addr == smt_pkg::ADDR_UPD && !upd_busy;
   endsequence
   sequence s_run;
      ##124 upd_busy ##1 !upd_busy;
   endsequence
   property p_ack; req[0].vld |=> rsp[0].ack; endproperty
   a_ack: assert property (p_ack) else $error("missing ack");
   property p_quiet; !req[1].vld |=> !rsp[1].ack; endproperty
   a_quiet: assert property (p_quiet) else $error("stray ack");
   property p_prim; primary_thread == 2'b01; endproperty
   a_prim: assert property (p_prim) else $error("bad primary");
   property p_thr; id[0][0] == 1'b0 && id[1][0] == 1'b1; endproperty
   a_thr: assert property (p_thr) else $error("bad thread bit");
   property p_uniq; id[0] != id[1]; endproperty
   a_uniq: assert property (p_uniq) else $error("ids equal");
   property p_adj; id[1] == (id[0] | 8'h01); endproperty
   a_adj: assert property (p_adj) else $error("ids not adjacent");
   property p_run; $rose(upd_busy) |-> s_run; endproperty
   a_run: assert property (p_run) else $error("bad update length");
   property p_upd; s_trig |-> ##2 upd_busy; endproperty
   a_upd: assert property (p_upd) else $error("update not started");
endmodule : smt_core_checker

/* File: tb/smt_evt_src.sv */
// Event source standing in for one thread's pipeline.
`timescale 1ns/100ps
module smt_evt_src (
   input  wire logic [smt_pkg::EVT_W-1:0] fire,
   input  wire logic                      clk,
   output logic      [smt_pkg::EVT_W-1:0] events
);
   // Each fire bit raises its event line one cycle later.
   always_ff @(posedge clk) begin
      events <= fire;
   end
endmodule : smt_evt_src

/* File: tb/smt_core_tb.sv */
// Self-checking bench for the core block.
`timescale 1ns/100ps
module smt_core_tb;
   logic                    clk = 1'b0;
   logic                    sys_rst = 1'b1;
   smt_pkg::smt_req_t [1:0] req = '0;
   smt_pkg::smt_rsp_t [1:0] rsp;
   logic [7:0]              fire = '0;
   logic [7:0]              ev1;
   logic [63:0]             misc;
   logic [1:0][7:0]         id;
   logic [1:0]              prim;
   logic                    busy;
   logic [1:0]              irq;
   logic [1:0]              hit;
   logic [1:0]              hit_seen = '0;
   logic [1:0]              cwid = 2'h1;
   int                      fails = 0;
   int                      samples_checked = 0;
   // Free-running clock.
   always #4 clk = ~clk;
   smt_evt_src peer (.clk(clk), .fire(fire), .events(ev1));
   smt_core uut (.clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp),
      .events({ev1, 8'h00}), .cluster_index(2'h0), .socket_index(4'h1),
      .processor_core_index(2'h1), .core_field_width(cwid),
      .misc_feature_enable(misc),
      .initial_interrupt_controller_identifier(id), .primary_thread(prim),
      .ctr_irq(irq), .precise_hit(hit), .upd_busy(busy));
   // Remembers every precise-hit pulse so a later check cannot miss it.
   always @(posedge clk) begin
      if (!sys_rst) hit_seen <= hit_seen | hit;
   end
   task automatic chk(string n, logic [63:0] e, logic [63:0] s);
      samples_checked++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic acc(int t, logic w, logic [31:0] a, logic [63:0] d,
                      logic [63:0] e, logic er);
      @(posedge clk) req[t] <= '{1'b1, w, a, d};
      @(posedge clk) req[t] <= '0;
      #1 chk("ack", 64'h1, 64'(rsp[t].ack));
      chk("err", 64'(er), 64'(rsp[t].err));
      if (!w) chk("rdata", e, rsp[t].rdata);
   endtask : acc
   task automatic t_ident;
      #1 chk("id0", 64'h6, 64'(id[0]));
      chk("id1", 64'h7, 64'(id[1]));
      chk("primary", 64'h1, 64'(prim));
   endtask : t_ident
   task automatic t_shared;
      acc(0, 1, smt_pkg::ADDR_MISC, 64'h5a, 0, 0);
      acc(1, 0, smt_pkg::ADDR_MISC, 0, 64'h5a, 0);
      chk("misc", 64'h5a, misc);
   endtask : t_shared
   task automatic t_sig;
      acc(0, 1, smt_pkg::ADDR_SIG, 64'h1234, 0, 0);
      acc(1, 0, smt_pkg::ADDR_SIG, 0, smt_pkg::SIG_RST, 0);
      acc(1, 0, 32'h0000_0005, 0, 0, 1);
   endtask : t_sig
   task automatic t_ctr;
      acc(0, 1, smt_pkg::ADDR_ALLOC, 64'h1, 0, 0);
      acc(1, 1, smt_pkg::ADDR_EVSEL0, 64'h0a, 0, 0);
      repeat (3) begin
         @(posedge clk) fire <= 8'h04;
         @(posedge clk) fire <= 8'h00;
      end
      repeat (4) @(posedge clk);
      acc(0, 0, smt_pkg::ADDR_CTR0, 0, 64'h3, 0);
   endtask : t_ctr
   task automatic t_ovf;
      acc(1, 1, smt_pkg::ADDR_EVSEL0, 64'h3a, 0, 0);
      acc(0, 1, smt_pkg::ADDR_CTR0, 64'hffff_ffff_ffff, 0, 0);
      @(posedge clk) fire <= 8'h04;
      @(posedge clk) fire <= 8'h00;
      repeat (4) @(posedge clk);
      #1 chk("irq", 64'h2, 64'(irq));
      chk("precise", 64'h2, 64'(hit_seen));
      acc(1, 0, smt_pkg::ADDR_STAT, 0, 64'h1, 0);
      acc(1, 1, smt_pkg::ADDR_STAT, 64'h1, 0, 0);
      #1 chk("irq clear", 64'h0, 64'(irq));
   endtask : t_ovf
   task automatic t_reset;
      @(posedge clk) begin
         sys_rst <= 1'b1;
         cwid    <= 2'h0;
      end
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1 chk("id0 flat", 64'h2, 64'(id[0]));
      chk("id1 flat", 64'h3, 64'(id[1]));
      chk("misc rst", 64'h0, misc);
      chk("busy rst", 64'h0, 64'(busy));
      acc(1, 0, smt_pkg::ADDR_IDENT, 0, 64'h3, 0);
   endtask : t_reset
   task automatic t_upd;
      @(posedge clk) begin
         req[0] <= '{1'b1, 1'b1, smt_pkg::ADDR_UPD, 64'ha};
         req[1] <= '{1'b1, 1'b1, smt_pkg::ADDR_UPD, 64'hb};
      end
      @(posedge clk) req <= '0;
      acc(0, 0, smt_pkg::ADDR_STAT, 0, 64'h300, 0);
      chk("busy", 64'h1, 64'(busy));
      repeat (2 * smt_pkg::UPD_CYCLES + 8) @(posedge clk);
      acc(0, 0, smt_pkg::ADDR_SIG, 0, {32'ha, 32'h0}, 0);
      acc(1, 0, smt_pkg::ADDR_SIG, 0, {32'ha, 32'h0}, 0);
   endtask : t_upd
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   // Main sequence.
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_ident();
      t_shared();
      t_sig();
      t_ctr();
      t_ovf();
      t_upd();
      t_reset();
      print_verdict();
   end
   // Watchdog against a hang.
   initial begin
      #16000;
      fails++;
      print_verdict();
   end
endmodule : smt_core_tb
bind smt_core smt_core_checker u_chk (.clk(clk), .sys_rst(sys_rst),
   .req(req), .rsp(rsp), .primary_thread(primary_thread),
   .initial_interrupt_controller_identifier(
      initial_interrupt_controller_identifier), .upd_busy(upd_busy));
